// *** hw/oag_core.sv ***
// Purpose: Operand address generation and field decoding for a 16-bit DSP
// Assumes: RAM and program memory answer a read in the request cycle
// Notes:   Registers reached over AHB-Lite, zero wait states
// Function
// - Upper field bits choose pointer post-change
// - Lower field bits pick pointer or short
// - Instruction bit 8 selects RAM bank, except in direct mode
// - Loop size from status bits 2-0
// - Modulo update touches only low bits
// - Wrap to lowest up, highest down
// - Updated value replaces pointer, no copy
// - Direct mode takes nine-bit address
// - Direct below 256 bank 0, else 1
// - Short direct from status and field bits
// - Short form accepted wherever indirect is
// - Register field decode, two read-only codes
// - Indirect uses selected pointer as address
// - Double indirect: RAM word addresses program
// - Program memory indirect writes only the incremented address
// - RAM program address incremented after use
// - Short slot gives program address too
// - Accumulator-indirect reads program memory
// - Long immediate copied unchanged
// - Short immediate loads pointer only
// - Loop code 0 is 256, else power
// - Status bits form short address high half
// - Six 8-bit pointers, software accessible
`default_nettype none
module oag_core
	import oag_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// AHB-Lite slave
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	// Data RAM port
	output oag_ram_req_t      ram_req,
	input  wire logic [15:0]  ram_rdata,
	// Program memory port
	output oag_pm_req_t       pm_req,
	input  wire logic [15:0]  pm_rdata,
	// Operation finished
	output logic              done
);
	localparam int PTR_W = 8;
	if (PTR_W != 8) begin : g_chk
		$error("Pointer width must be 8");
	end

	// Loop mask from code
	// Loop code decode
	function automatic logic [7:0] loop_mask(input logic [2:0] code);
		loop_mask = (code == 3'h0) ? 8'hFF : 8'((9'h002 << (code - 3'h1)) - 9'h001);
	endfunction

	// Post-access pointer change
	function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic [1:0] m, input logic [2:0] code);
		logic [7:0] msk;
		logic [7:0] lo;
		msk = loop_mask(code);
		lo  = 8'h00;
		ptr_next = p;
		case (m)
			MOD_INC: ptr_next = p + 8'h01;
			MOD_DECL: begin
				lo = (p - 8'h01) & msk;
				ptr_next = (p & ~msk) | lo;
			end
			MOD_INCL: begin
				lo = (p + 8'h01) & msk;
				ptr_next = (p & ~msk) | lo;
			end
			default: ptr_next = p;
		endcase
	endfunction

	// Software-visible state
	logic [7:0]  ptr_q [0:5];
	logic [15:0] status_q;
	logic [23:0] acc_q;
	logic [15:0] opnd_q;
	logic [15:0] cmd_q;
	logic [15:0] result_q;
	logic [15:0] pmaddr_q;
	logic [7:0]  ramadr_q;
	logic        bankr_q;
	logic [3:0]  regdec_q;
	logic        ro_q;
	oag_state_t  state_q;

	// Command fields: [2:0] mode, [8] bank, [3:0] of opnd field in cmd[15:12]
	oag_mode_t   mode;
	logic [3:0]  fld;
	logic        bank;
	logic [2:0]  pidx;
	logic        short_sel;
	logic [7:0]  ind_addr;
	logic [7:0]  short_addr;
	assign mode = oag_mode_t'(cmd_q[2:0]);
	assign fld  = cmd_q[15:12];
	assign bank = cmd_q[BANK_BIT];
	assign short_sel = (fld[1:0] == SEL_SHORT);
	assign pidx = {1'b0, fld[1:0]} + (bank ? 3'd3 : 3'd0);
	assign short_addr = {4'h0, status_q[4], status_q[3], fld[3:2]};
	assign ind_addr = short_sel ? short_addr : ptr_q[pidx];

	// Operand location for a command being started
	logic [2:0]  start_pidx;
	logic [7:0]  start_addr;
	assign start_pidx = {1'b0, hwdata[13:12]} + (hwdata[BANK_BIT] ? 3'd3 : 3'd0);
	assign start_addr = (hwdata[13:12] == SEL_SHORT) ?
		{4'h0, status_q[4], status_q[3], hwdata[15:14]} : ptr_q[start_pidx];

	// AHB address phase capture
	logic        wr_q;
	logic        rd_q;
	logic [7:0]  adr_q;
	logic        start;
	logic        accept;
	assign accept = hsel && hready && htrans[1];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			adr_q <= 8'h00;
		end else begin
			wr_q  <= accept && hwrite;
			rd_q  <= accept && !hwrite;
			adr_q <= accept ? haddr[7:0] : adr_q;
		end
	end
	assign start = wr_q && (adr_q == OFF_CMD) && hwdata[3] && (state_q == ST_IDLE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (accept && !hwrite) begin
			case (haddr[7:0])
				OFF_STATUS: hrdata <= {16'h0000, status_q};
				OFF_ACC:    hrdata <= {8'h00, acc_q};
				OFF_OPND:   hrdata <= {16'h0000, opnd_q};
				OFF_CMD:    hrdata <= {16'h0000, cmd_q[15:4], state_q == ST_IDLE, cmd_q[2:0]};
				OFF_RESULT: hrdata <= {16'h0000, result_q};
				OFF_PMADDR: hrdata <= {16'h0000, pmaddr_q};
				OFF_DECODE: hrdata <= {27'h000_0000, ro_q, regdec_q};
				OFF_RAMADR: hrdata <= {23'h00_0000, bankr_q, ramadr_q};
				default: begin
					if (haddr[7:5] == 3'h0 && haddr[4:2] < 3'd6) begin
						hrdata <= {24'h00_0000, ptr_q[haddr[4:2]]};
					end else begin
						hrdata <= 32'h0000_0000;
					end
				end
			endcase
		end
	end

	// Status, accumulator, operand and command registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= STATUS_RST;
			acc_q    <= ACC_RST;
			opnd_q   <= 16'h0000;
			cmd_q    <= 16'h0000;
		end else if (wr_q) begin
			case (adr_q)
				OFF_STATUS: status_q <= hwdata[15:0];
				OFF_ACC:    acc_q    <= hwdata[23:0];
				OFF_OPND:   opnd_q   <= hwdata[15:0];
				OFF_CMD:    cmd_q    <= (state_q == ST_IDLE) ? {hwdata[15:4], 1'b0, hwdata[2:0]} : cmd_q;
				default:    cmd_q    <= cmd_q;
			endcase
		end
	end

	// Register operand decode
	// Bus readback and product read-only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regdec_q <= REG_BUS;
			ro_q     <= 1'b1;
		end else if (start) begin
			regdec_q <= hwdata[15:12];
			ro_q     <= (hwdata[15:12] == REG_BUS) || (hwdata[15:12] == REG_PROD);
		end
	end

	// Sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE:  state_q <= start ? ST_RAMRD : ST_IDLE;
				ST_RAMRD: state_q <= (mode == MODE_MEMIND) ? ST_PMRD :
					(mode == MODE_ACCIND) ? ST_RAMWB : ST_DONE;
				ST_PMRD:  state_q <= ST_RAMWB;
				ST_RAMWB: state_q <= ST_DONE;
				ST_DONE:  state_q <= ST_IDLE;
				default:  state_q <= ST_IDLE;
			endcase
		end
	end

	// Memory requests
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ram_req  <= '0;
			pm_req   <= '0;
			ramadr_q <= 8'h00;
			bankr_q  <= 1'b0;
		end else begin
			ram_req <= '0;
			pm_req  <= '0;
			if (state_q == ST_IDLE && start) begin
				case (oag_mode_t'(hwdata[2:0]))
					MODE_DIRECT: begin
						ram_req.en    <= 1'b1;
						ram_req.we    <= hwdata[4];
						ram_req.bank  <= opnd_q[8];
						ram_req.addr  <= opnd_q[7:0];
						ram_req.wdata <= acc_q[23:8];
						ramadr_q      <= opnd_q[7:0];
						bankr_q       <= opnd_q[8];
					end
					MODE_ACCIND: begin
						pm_req.en   <= 1'b1;
						pm_req.addr <= acc_q[23:8];
					end
					MODE_REGIND, MODE_MEMIND: begin
						ram_req.en    <= 1'b1;
						ram_req.we    <= hwdata[4] && (oag_mode_t'(hwdata[2:0]) != MODE_MEMIND);
						ram_req.bank  <= hwdata[BANK_BIT];
						ram_req.addr  <= start_addr;
						ram_req.wdata <= opnd_q;
						ramadr_q      <= start_addr;
						bankr_q       <= hwdata[BANK_BIT];
					end
					default: ram_req.en <= 1'b0;
				endcase
			end else if (state_q == ST_RAMRD && mode == MODE_MEMIND) begin
				pm_req.en   <= 1'b1;
				pm_req.addr <= ram_rdata;
				ramadr_q    <= ind_addr;
				bankr_q     <= bank;
			end else if (state_q == ST_PMRD) begin
				ram_req.en    <= 1'b1;
				ram_req.we    <= 1'b1;
				ram_req.bank  <= bankr_q;
				ram_req.addr  <= ramadr_q;
				ram_req.wdata <= pmaddr_q + 16'h0001;
			end
		end
	end

	// Fetched data and program address capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_q <= 16'h0000;
			pmaddr_q <= 16'h0000;
		end else if (start && oag_mode_t'(hwdata[2:0]) == MODE_LIMM) begin
			result_q <= opnd_q;
		end else if (state_q == ST_RAMRD) begin
			// Only reads that fetch a word update the result
			if (mode == MODE_ACCIND) begin
				result_q <= pm_rdata;
			end else if (mode == MODE_MEMIND || ((mode == MODE_REGIND || mode == MODE_DIRECT) && !cmd_q[4])) begin
				result_q <= ram_rdata;
			end
			if (mode == MODE_MEMIND || mode == MODE_ACCIND) begin
				pmaddr_q <= (mode == MODE_ACCIND) ? acc_q[23:8] : ram_rdata;
			end
		end else if (state_q == ST_PMRD) begin
			result_q <= pm_rdata;
		end
	end

	// Pointer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 6; i++) begin
				ptr_q[i] <= PTR_RST;
			end
		end else if (wr_q && adr_q[7:5] == 3'h0 && adr_q[4:2] < 3'd6) begin
			ptr_q[adr_q[4:2]] <= hwdata[7:0];
		end else if (start && oag_mode_t'(hwdata[2:0]) == MODE_SIMM && hwdata[13:12] != SEL_SHORT) begin
			ptr_q[start_pidx] <= opnd_q[7:0];
		end else if (state_q == ST_DONE && !short_sel &&
			(mode == MODE_REGIND || mode == MODE_MEMIND)) begin
			ptr_q[pidx] <= ptr_next(ptr_q[pidx], fld[3:2], status_q[2:0]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done <= 1'b0;
		end else begin
			done <= (state_q == ST_DONE);
		end
	end

	// Assertions
	AST_INCL_WRAP: assert property (@(posedge clk) disable iff (rst)
		ptr_next(8'hBF, MOD_INCL, 3'h5) == 8'hA0) else $error("Loop increment wrap wrong");
	AST_DECL_WRAP: assert property (@(posedge clk) disable iff (rst)
		ptr_next(8'hA0, MOD_DECL, 3'h5) == 8'hBF) else $error("Loop decrement wrap wrong");
	AST_UPPER_KEEP: assert property (@(posedge clk) disable iff (rst)
		(state_q == ST_DONE && !short_sel && mode == MODE_REGIND && fld[3]) |=>
		((ptr_q[$past(pidx)] & ~loop_mask($past(status_q[2:0]))) ==
		($past(ptr_q[pidx]) & ~loop_mask($past(status_q[2:0]))))) else $error("Upper pointer bits changed");
	AST_LOOP256: assert property (@(posedge clk) disable iff (rst)
		loop_mask(3'h0) == 8'hFF && loop_mask(3'h7) == 8'h7F) else $error("Loop size decode wrong");
	AST_PM_NOWR: assert property (@(posedge clk) disable iff (rst)
		(start && oag_mode_t'(hwdata[2:0]) == MODE_MEMIND) |=> ram_req.en && !ram_req.we)
		else $error("Memory indirect performed a write");
	AST_PM_ADDR: assert property (@(posedge clk) disable iff (rst)
		(state_q == ST_RAMRD && mode == MODE_MEMIND) |=> pm_req.en && pm_req.addr == $past(ram_rdata))
		else $error("Program address not from RAM");
	AST_WB_INC: assert property (@(posedge clk) disable iff (rst)
		(state_q == ST_PMRD) |=> ram_req.we && ram_req.wdata == $past(pmaddr_q) + 16'h0001)
		else $error("Program address not incremented");
	AST_ACC_ADDR: assert property (@(posedge clk) disable iff (rst)
		(start && oag_mode_t'(hwdata[2:0]) == MODE_ACCIND) |=> pm_req.en && pm_req.addr == $past(acc_q[23:8]))
		else $error("Accumulator address wrong");
	AST_DIRECT_BANK: assert property (@(posedge clk) disable iff (rst)
		(start && oag_mode_t'(hwdata[2:0]) == MODE_DIRECT) |=> ram_req.bank == $past(opnd_q[8]))
		else $error("Direct bank wrong");
	AST_DONE_SEQ: assert property (@(posedge clk) disable iff (rst)
		(start && oag_mode_t'(hwdata[2:0]) == MODE_MEMIND) |-> ##[4:5] done) else $error("Memory indirect too slow");
endmodule
`default_nettype wire

// *** shared/oag_pkg.sv ***
// Purpose: Shared constants and types for the operand address generator
// Assumes: 16-bit data path, two 256-word data RAM banks
// Notes:   Register bus map uses one aligned word per register
`default_nettype none
package oag_pkg;
	// Pointer field modification codes
	localparam logic [1:0] MOD_NONE = 2'h0;
	localparam logic [1:0] MOD_INC  = 2'h1;
	localparam logic [1:0] MOD_DECL = 2'h2;
	localparam logic [1:0] MOD_INCL = 2'h3;
	localparam logic [1:0] SEL_SHORT = 2'h3;
	// Instruction field positions
	localparam int BANK_BIT  = 8;
	localparam int FIELD_LSB = 0;
	// Register operand codes
	localparam logic [3:0] REG_BUS    = 4'h0;
	localparam logic [3:0] REG_X      = 4'h1;
	localparam logic [3:0] REG_Y      = 4'h2;
	localparam logic [3:0] REG_ACC    = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_STACK  = 4'h5;
	localparam logic [3:0] REG_PC     = 4'h6;
	localparam logic [3:0] REG_PROD   = 4'h7;
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_PTR0   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_ACC    = 8'h1C;
	localparam logic [7:0] OFF_OPND   = 8'h20;
	localparam logic [7:0] OFF_CMD    = 8'h24;
	localparam logic [7:0] OFF_RESULT = 8'h28;
	localparam logic [7:0] OFF_PMADDR = 8'h2C;
	localparam logic [7:0] OFF_DECODE = 8'h30;
	localparam logic [7:0] OFF_RAMADR = 8'h34;
	// Reset values
	localparam logic [7:0]  PTR_RST    = 8'h00;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [23:0] ACC_RST    = 24'h00_0000;

	// Operand modes written to the command register
	typedef enum logic [2:0] {
		MODE_REGIND = 3'b000,
		MODE_DIRECT = 3'b001,
		MODE_MEMIND = 3'b010,
		MODE_ACCIND = 3'b011,
		MODE_LIMM   = 3'b100,
		MODE_SIMM   = 3'b101,
		MODE_REGDEC = 3'b110
	} oag_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_RAMRD  = 3'b001,
		ST_PMRD   = 3'b010,
		ST_RAMWB  = 3'b011,
		ST_DONE   = 3'b100
	} oag_state_t;

	// Data RAM request
	typedef struct packed {
		logic        en;
		logic        we;
		logic        bank;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} oag_ram_req_t;

	// Program memory request (read only)
	typedef struct packed {
		logic        en;
		logic [15:0] addr;
	} oag_pm_req_t;
endpackage
`default_nettype wire

// *** verif/dsp_operand_address_gen_bench.sv ***
// Purpose: Self-checking bench for the operand address generator
// Assumes: Memory model answers in the request cycle
// Notes:   Every memory request is logged and compared
`default_nettype none
module dsp_operand_address_gen_bench
	import oag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk, rst, hsel, hwrite, hreadyout, hresp, done, b;
	logic [31:0]  haddr, hwdata, hrdata, r;
	logic [1:0]   htrans, md, s, st;
	logic [2:0]   hsize;
	logic [15:0]  ram_rdata, pm_rdata, w;
	logic [15:0]  m [512];
	logic [31:0]  evq [$];
	logic [31:0]  exq [$];
	logic [7:0]   pv, ra;
	logic [23:0]  av;
	logic [8:0]   da;
	logic [8:0]   dl [4] = '{9'h0ff, 9'h100, 9'h000, 9'h1ff};
	oag_ram_req_t ram_req;
	oag_pm_req_t  pm_req;
	int           err_count, tests_run, cyc, dn, seed;

	oag_core i_oag_core (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ram_req(ram_req), .ram_rdata(ram_rdata), .pm_req(pm_req), .pm_rdata(pm_rdata),
		.done(done));
	oag_mem_model i_oag_mem_model (.clk(clk), .ram_req(ram_req), .pm_req(pm_req), .ram_rdata(ram_rdata),
		.pm_rdata(pm_rdata));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Request log, done count and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (done === 1'b1) dn <= dn + 1;
		if (ram_req.en === 1'b1) evq.push_back({4'h0, 2'h1, ram_req.we, ram_req.bank, ram_req.addr,
			ram_req.we ? ram_req.wdata : 16'h0000});
		if (pm_req.en === 1'b1) evq.push_back({4'h0, 2'h2, 10'h000, pm_req.addr});
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end

	function automatic logic [31:0] ev(input logic [1:0] k, input logic we, input logic bk,
		input logic [7:0] a, input logic [15:0] d);
		ev = {4'h0, k, we, bk, a, d};
	endfunction
	function automatic logic [7:0] msk(input logic [2:0] c);
		msk = (c == 3'h0) ? 8'hff : 8'((9'h001 << c) - 9'h001);
	endfunction
	function automatic logic [7:0] nxt(input logic [7:0] p, input logic [1:0] c, input logic [2:0] l);
		case (c)
			MOD_INC: nxt = 8'(p + 8'h01);
			MOD_DECL: nxt = (p & ~msk(l)) | (8'(p - 8'h01) & msk(l));
			MOD_INCL: nxt = (p & ~msk(l)) | (8'(p + 8'h01) & msk(l));
			default: nxt = p;
		endcase
	endfunction

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		r = hrdata;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(n, e, r);
	endtask
	task automatic echk(input string n);
		chk({n, " count"}, 32'(exq.size()), 32'(evq.size()));
		foreach (exq[i]) chk(n, exq[i], evq[i]);
		exq.delete();
		evq.delete();
	endtask
	task automatic go(input logic [15:0] c);
		int d0;
		d0 = dn;
		bus(1'b1, OFF_CMD, {16'h0000, c | 16'h0008});
		for (int n = 0; n < 60 && dn == d0; n++) @(posedge clk);
		if (dn == d0) chk("done", 32'h0000_0001, 32'h0000_0000);
	endtask
	task automatic results;
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		seed = 32'ha133d7ca;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		for (int i = 0; i < 512; i++) m[i] = 16'(i * 37) ^ 16'h5a00;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++) rchk("ptr reset", 8'(4 * i), 32'h0000_0000);
		rchk("status reset", OFF_STATUS, 32'h0000_0000);
		rchk("unmapped", 8'h80, 32'h0000_0000);
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
		chk("hready", 32'h0000_0001, {31'h0, hreadyout});
		$display("reset test done");
		for (int t = 0; t < 40; t++) begin
			{b, pv} = 9'($random(seed));
			s = 2'(($random(seed) & 32'h7fff_ffff) % 3);
			md = t[4:3];
			pv = t[0] ? (pv | msk(t[2:0])) : (pv & ~msk(t[2:0]));
			bus(1'b1, 8'(4 * (b * 3 + s)), {24'h00_0000, pv});
			bus(1'b1, OFF_STATUS, {29'h0000_0000, t[2:0]});
			go({md, s, 3'h0, b, 5'h00, MODE_REGIND});
			exq.push_back(ev(2'h1, 1'b0, b, pv, 16'h0000));
			echk("ptr access");
			rchk("ptr data", OFF_RESULT, {16'h0000, m[{b, pv}]});
			rchk("ptr update", 8'(4 * (b * 3 + s)), {24'h00_0000, nxt(pv, md, t[2:0])});
		end
		$display("indirect test done");
		for (int t = 0; t < 16; t++) begin
			st = t[1:0];
			b = t[0] ^ t[3];
			bus(1'b1, OFF_STATUS, {27'h000_0000, st, 3'h1});
			go({t[3:2], 2'h3, 3'h0, b, 5'h00, MODE_REGIND});
			exq.push_back(ev(2'h1, 1'b0, b, {4'h0, st, t[3:2]}, 16'h0000));
			echk("short access");
			rchk("short data", OFF_RESULT, {16'h0000, m[{b, 4'h0, st, t[3:2]}]});
		end
		$display("short test done");
		for (int t = 0; t < 4; t++) begin
			{b, pv} = 9'($random(seed));
			w = 16'($random(seed));
			bus(1'b1, 8'(4 * (b * 3 + 2)), {24'h00_0000, pv});
			bus(1'b1, OFF_OPND, {16'h0000, w});
			go({2'h1, 2'h2, 3'h0, b, 3'h0, 1'b1, 1'b0, MODE_REGIND});
			exq.push_back(ev(2'h1, 1'b1, b, pv, w));
			echk("ptr write");
			m[{b, pv}] = w;
			rchk("ptr write update", 8'(4 * (b * 3 + 2)), {24'h00_0000, 8'(pv + 8'h01)});
			rchk("ram addr", OFF_RAMADR, {23'h00_0000, b, pv});
		end
		$display("pointer write test done");
		for (int t = 0; t < 8; t++) begin
			da = t[2] ? 9'($random(seed)) : dl[t[1:0]];
			av = 24'($random(seed));
			bus(1'b1, OFF_OPND, {23'h00_0000, da});
			bus(1'b1, OFF_ACC, {8'h00, av});
			go({11'h000, t[0], 1'b0, MODE_DIRECT});
			exq.push_back(ev(2'h1, t[0], da[8], da[7:0], t[0] ? av[23:8] : 16'h0000));
			echk("direct access");
			if (t[0]) m[da] = av[23:8];
			else rchk("direct data", OFF_RESULT, {16'h0000, m[da]});
		end
		$display("direct test done");
		for (int t = 0; t < 8; t++) begin
			b = t[1];
			s = t[2] ? 2'h3 : 2'h1;
			md = t[2] ? 2'h0 : 2'h3;
			if (t[0] == 0) begin
				pv = 8'($random(seed));
				bus(1'b1, OFF_STATUS, {27'h000_0000, 2'h2, 3'h2});
				bus(1'b1, 8'(4 * (b * 3 + 1)), {24'h00_0000, pv});
			end
			ra = t[2] ? 8'h08 : pv;
			w = m[{b, ra}];
			go({md, s, 3'h0, b, 3'h0, t[0], 1'b0, MODE_MEMIND});
			exq.push_back(ev(2'h1, 1'b0, b, ra, 16'h0000));
			exq.push_back(ev(2'h2, 1'b0, 1'b0, 8'h00, w));
			exq.push_back(ev(2'h1, 1'b1, b, ra, 16'(w + 16'h0001)));
			echk("memind access");
			m[{b, ra}] = 16'(w + 16'h0001);
			rchk("memind data", OFF_RESULT, {16'h0000, w ^ 16'hc3a5});
			rchk("memind pm addr", OFF_PMADDR, {16'h0000, w});
			pv = nxt(pv, md, 3'h2);
			if (!t[2]) rchk("memind ptr", 8'(4 * (b * 3 + 1)), {24'h00_0000, pv});
		end
		$display("memind test done");
		for (int t = 0; t < 3; t++) begin
			av = 24'($random(seed));
			bus(1'b1, OFF_ACC, {8'h00, av});
			go({13'h0000, MODE_ACCIND});
			exq.push_back(ev(2'h2, 1'b0, 1'b0, 8'h00, av[23:8]));
			echk("accind access");
			rchk("accind data", OFF_RESULT, {16'h0000, av[23:8] ^ 16'hc3a5});
			rchk("accind pm addr", OFF_PMADDR, {16'h0000, av[23:8]});
		end
		$display("accind test done");
		for (int t = 0; t < 6; t++) begin
			w = 16'($random(seed));
			b = t[0];
			s = 2'(t / 2);
			bus(1'b1, OFF_OPND, {16'h0000, w});
			go({13'h0000, MODE_LIMM});
			rchk("long imm", OFF_RESULT, {16'h0000, w});
			go({2'h0, s, 3'h0, b, 5'h00, MODE_SIMM});
			rchk("short imm", 8'(4 * (b * 3 + s)), {24'h00_0000, w[7:0]});
		end
		for (int t = 0; t < 16; t++) begin
			go({4'(t), 9'h000, MODE_REGDEC});
			rchk("decode", OFF_DECODE, {27'h000_0000, t == 0 || t == 7, 4'(t)});
		end
		echk("no traffic");
		$display("immediate and decode test done");
		results();
	end
endmodule
`default_nettype wire

// *** verif/oag_mem_model.sv ***
// Purpose: Data RAM banks and program memory beside the generator
// Assumes: Read data stands in the request cycle, taken at the next edge
// Notes:   Idle read data inverts every cycle
`default_nettype none
module oag_mem_model
	import oag_pkg::*;
(
	// Clock
	input  wire logic         clk,
	// Requests
	input  wire oag_ram_req_t ram_req,
	input  wire oag_pm_req_t  pm_req,
	// Read data
	output logic [15:0]       ram_rdata,
	output logic [15:0]       pm_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [512];
	logic [15:0] idle_q;
	initial begin
		idle_q = 16'h0000;
		for (int i = 0; i < 512; i++) begin
			mem[i] = 16'(i * 37) ^ 16'h5a00;
		end
	end
	// Store writes; idle data toggles so a stale read shows
	always @(posedge clk) begin
		if (ram_req.en && ram_req.we) begin
			mem[{ram_req.bank, ram_req.addr}] <= ram_req.wdata;
		end
		idle_q <= ~idle_q;
	end
	// Answer while the request stands
	assign ram_rdata = (ram_req.en && !ram_req.we) ? mem[{ram_req.bank, ram_req.addr}] : idle_q;
	assign pm_rdata  = pm_req.en ? (pm_req.addr ^ 16'hc3a5) : ~idle_q;
endmodule
`default_nettype wire
